// ---- snc_top.sv ----
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "snc_defs.svh"

// How it works
// R1: Two cascaded integrators run per modulator bit.
// R2: Second difference runs once per word clock.
// R3: Natural output is unsigned, zero to full.
// R4: Signed format inverts top bit, sign-extends.
// R5: Divide-by-four makes phases and bit clock.
// R6: Internal timer makes word clock, sets decimation.
// R7: Timer raises sample-ready interrupt once per word.
// R8: Shift four/five single, two for double.
// R9: Rates 32 to 256, either modulator order.
// R10: Each channel picks unsigned or signed format.
// R11: Four channels, own settings, common sampling.
// R12: Phase swap moves sampling to second phase.
// R13: Host reads results within each sample period.
// R14: Latest control write governs the one filter.
// R15: Sample rate is clock/4/decimation rate.
// R16: Input is single comparator bit per channel.
// R17: Host discards two samples after input change.
// R18: Accumulators sized for rate 256 without overflow.
// R19: Word tick latches, differences, formats, flags ready.
module snc_top import snc_pkg::*; #(
  parameter int NCH   = 4,
  parameter int ACC_W = 17
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  mod_bit,
  output logic             phi1_o,
  output logic             phi2_o,
  output logic             irq_o
);

  // ========================================================================
  // Reset release and input synchronisers.
  logic       rst_s1_r;
  logic       rst_n_r;
  logic [3:0] bit_s1_r;
  logic [3:0] bit_s2_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bit_s1_r <= 4'h0;
      bit_s2_r <= 4'h0;
    end else begin
      bit_s1_r <= mod_bit;
      bit_s2_r <= bit_s1_r; // [R16]
    end
  end

  // ========================================================================
  // Register bus decode.
  logic [11:0] ctrl_r;
  logic [1:0]  status_r;
  logic [1:0]  mask_r;
  logic        ack_r;
  logic [31:0] rdat_r;

  wire        bus_req  = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        bus_wr   = bus_req & wb_we_i;
  wire        bus_rd   = bus_req & ~wb_we_i;
  wire        hit_ctrl = (wb_adr_i == `SNC_OFS_CTRL);
  wire        hit_stat = (wb_adr_i == `SNC_OFS_STATUS);
  wire        hit_mask = (wb_adr_i == `SNC_OFS_MASK);
  wire        hit_tmr  = (wb_adr_i == `SNC_OFS_TIMER);
  wire        hit_res  = (wb_adr_i >= `SNC_OFS_RES0) && (wb_adr_i <= `SNC_OFS_RES3)
                         && (wb_adr_i[1:0] == 2'h0);
  wire [1:0]  res_idx  = wb_adr_i[3:2];
  wire        ctrl_wr  = bus_wr & hit_ctrl & (wb_sel_i[0] | wb_sel_i[1]);

  // ========================================================================
  // Control fields.
  wire             run_en   = ctrl_r[`SNC_CTRL_EN];
  wire snc_rate_t  rate_sel = snc_rate_t'(ctrl_r[`SNC_CTRL_RATE +: 2]); // [R9]
  wire snc_order_t ord_sel  = snc_order_t'(ctrl_r[`SNC_CTRL_ORDER]); // [R9]
  wire [3:0]       output_format_select = ctrl_r[`SNC_CTRL_FMT +: 4]; // [R10]
  wire [3:0]       phase_swap = ctrl_r[`SNC_CTRL_SWAP +: 4]; // [R12]

  // ========================================================================
  // Divide-by-four phase generator.
  logic [1:0] ph_r;
  logic       phi1_r;
  logic       phi2_r;

  wire [1:0] ph_nxt  = (ph_r == `SNC_BIT_DIV) ? 2'h0 : ph_r + 2'h1;
  wire       tick_p1 = run_en & (ph_r == `SNC_TICK_PH1);
  wire       tick_p2 = run_en & (ph_r == `SNC_TICK_PH2);

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ph_r   <= 2'h0;
      phi1_r <= 1'b0;
      phi2_r <= 1'b0;
    end else if (!run_en) begin
      ph_r   <= 2'h0;
      phi1_r <= 1'b0;
      phi2_r <= 1'b0;
    end else begin
      ph_r   <= ph_nxt; // [R5] [R15]
      // Each phase is high for one cycle with a dead cycle between them.
      phi1_r <= (ph_nxt == 2'h0); // [R5]
      phi2_r <= (ph_nxt == 2'h2); // [R5]
    end
  end

  // ========================================================================
  // Decimation timer and word clock.
  logic [7:0] tmr_r;
  logic       word_r;

  wire [7:0] tmr_lim  = 8'((9'h001 << snc_rate_log(rate_sel)) - 9'h001);
  wire       tmr_wrap = tick_p2 & (tmr_r == tmr_lim);

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tmr_r  <= 8'h00;
      word_r <= 1'b0;
    end else if (ctrl_wr || !run_en) begin
      tmr_r  <= 8'h00; // [R14]
      word_r <= 1'b0;
    end else begin
      if (tick_p2) begin
        tmr_r <= tmr_wrap ? 8'h00 : tmr_r + 8'h01; // [R6] [R15]
      end
      // Word tick lands after both phases of the last bit have integrated.
      word_r <= tmr_wrap; // [R6]
    end
  end

  // ========================================================================
  // Channels.
  snc_ch_if ch_if[NCH] ();
  logic [NCH-1:0] ready_w;
  logic [15:0]    res_w [NCH];

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign ch_if[i].clk        = clock;
    assign ch_if[i].rst_n      = rst_n_r;
    assign ch_if[i].clr        = ctrl_wr | ~run_en; // [R14]
    assign ch_if[i].bit_en     = phase_swap[i] ? tick_p2 : tick_p1; // [R5] [R11] [R12]
    assign ch_if[i].bit_in     = bit_s2_r[i];
    assign ch_if[i].word_en    = word_r; // [R11]
    assign ch_if[i].rate       = rate_sel;
    assign ch_if[i].order      = ord_sel;
    assign ch_if[i].fmt_signed = output_format_select[i]; // [R10]
    assign ready_w[i]          = ch_if[i].ready;
    assign res_w[i]            = ch_if[i].result;

    snc_chan #(
      .ACC_W (ACC_W) // [R18]
    ) u_chan (
      .ch (ch_if[i])
    );
  end

  // ========================================================================
  // Status, mask and interrupt.
  wire sample_rdy = ready_w[0];
  wire stat_clr   = bus_rd & hit_stat;
  wire [1:0] stat_set = {sample_rdy & status_r[`SNC_ST_READY], sample_rdy};
  // A new event in the clearing cycle survives the clear.
  wire [1:0] status_nxt = (stat_clr ? 2'h0 : status_r) | stat_set;

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      status_r <= 2'h0;
      irq_o    <= 1'b0;
    end else begin
      status_r <= status_nxt; // [R7]
      irq_o    <= |(status_nxt & mask_r); // [R7]
    end
  end

  // ========================================================================
  // Register writes and read answer.
  wire [31:0] rd_mux = hit_ctrl ? {20'h00000, ctrl_r} :
                       hit_stat ? {30'h0, status_r} :
                       hit_mask ? {30'h0, mask_r} :
                       hit_tmr  ? {24'h000000, tmr_r} :
                       hit_res  ? {16'h0000, res_w[res_idx]} : 32'h00000000; // [R13]

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= `SNC_CTRL_RST;
      mask_r <= `SNC_MASK_RST;
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req;
      if (bus_rd) begin
        rdat_r <= rd_mux;
      end
      if (ctrl_wr && wb_sel_i[0]) begin
        ctrl_r[7:0] <= wb_dat_i[7:0]; // [R14]
      end
      if (ctrl_wr && wb_sel_i[1]) begin
        ctrl_r[11:8] <= wb_dat_i[11:8]; // [R14]
      end
      if (bus_wr && hit_mask && wb_sel_i[0]) begin
        mask_r <= wb_dat_i[1:0];
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign phi1_o   = phi1_r;
  assign phi2_o   = phi2_r;

endmodule : snc_top

// ---- snc_defs.svh ----
`ifndef SNC_DEFS_SVH
`define SNC_DEFS_SVH

// ==========================================================================
// Register byte offsets.
`define SNC_OFS_CTRL    8'h00
`define SNC_OFS_STATUS  8'h04
`define SNC_OFS_MASK    8'h08
`define SNC_OFS_TIMER   8'h0c
`define SNC_OFS_RES0    8'h10
`define SNC_OFS_RES3    8'h1c

// ==========================================================================
// Control field positions.
`define SNC_CTRL_EN     0
`define SNC_CTRL_RATE   1
`define SNC_CTRL_ORDER  3
`define SNC_CTRL_FMT    4
`define SNC_CTRL_SWAP   8

// ==========================================================================
// Status field positions and reset values.
`define SNC_ST_READY    0
`define SNC_ST_OVERRUN  1
`define SNC_CTRL_RST    12'h000
`define SNC_MASK_RST    2'h0

// ==========================================================================
// Timing counts in clock cycles and the smallest rate logarithm.
`define SNC_BIT_DIV     2'h3
`define SNC_TICK_PH1    2'h1
`define SNC_TICK_PH2    2'h3
`define SNC_RATE_LOG_MIN 4'h5

`endif

// ---- snc_pkg.sv ----
`include "snc_defs.svh"

package snc_pkg;

  // ========================================================================
  // Modes.
  typedef enum logic [1:0] {
    SNC_RATE_32  = 2'h0,
    SNC_RATE_64  = 2'h1,
    SNC_RATE_128 = 2'h2,
    SNC_RATE_256 = 2'h3
  } snc_rate_t;

  typedef enum logic {
    SNC_SINGLE = 1'b0,
    SNC_DOUBLE = 1'b1
  } snc_order_t;

  // ========================================================================
  // Right shift by rate and modulator order.
  function automatic logic [3:0] snc_shift(input snc_order_t ord, input snc_rate_t rate);
    if (ord == SNC_DOUBLE) begin
      snc_shift = 4'h2;
    end else if (rate == SNC_RATE_32 || rate == SNC_RATE_64) begin
      snc_shift = 4'h4;
    end else begin
      snc_shift = 4'h5;
    end
  endfunction : snc_shift

  // Base two logarithm of the decimation rate.
  function automatic logic [3:0] snc_rate_log(input snc_rate_t rate);
    snc_rate_log = `SNC_RATE_LOG_MIN + {2'h0, rate};
  endfunction : snc_rate_log

endpackage : snc_pkg

// ---- snc_ch_if.sv ----
`timescale 1ns/1ps

interface snc_ch_if import snc_pkg::*; ();
  logic        clk;
  logic        rst_n;
  logic        clr;
  logic        bit_en;
  logic        bit_in;
  logic        word_en;
  snc_rate_t   rate;
  snc_order_t  order;
  logic        fmt_signed;
  logic [15:0] result;
  logic        ready;

  modport ctl  (output clk, rst_n, clr, bit_en, bit_in, word_en, rate, order, fmt_signed,
                input result, ready);
  modport filt (input clk, rst_n, clr, bit_en, bit_in, word_en, rate, order, fmt_signed,
                output result, ready);
endinterface : snc_ch_if

// ---- snc_chan.sv ----
`timescale 1ns/1ps

module snc_chan import snc_pkg::*; #(
  parameter int ACC_W = 17
) (
  snc_ch_if.filt ch
);

  // ========================================================================
  // Double integrator and second difference.
  logic [ACC_W-1:0] int1_r;
  logic [ACC_W-1:0] int2_r;
  logic [ACC_W-1:0] last_r;
  logic [ACC_W-1:0] diff_r;
  logic [15:0]      result_r;
  logic             ready_r;

  wire [ACC_W-1:0] diff1  = int2_r - last_r;
  wire [ACC_W-1:0] diff2  = diff1 - diff_r;
  wire [3:0]       shamt  = snc_shift(ch.order, ch.rate);
  wire [3:0]       nbits  = 4'((snc_rate_log(ch.rate) << 1) - shamt);
  wire [ACC_W-1:0] scaled = diff2 >> shamt;
  wire [ACC_W-1:0] full   = (ACC_W'(1) << nbits) - ACC_W'(1);
  wire [ACC_W-1:0] top    = ACC_W'(1) << (nbits - 4'h1);
  // Only the exact full-scale input reaches 2^n, so it is clipped to 2^n-1.
  wire [ACC_W-1:0] sat    = (scaled > full) ? full : scaled;
  wire [ACC_W-1:0] flip   = sat ^ top;
  wire             neg    = |(flip & top);
  wire [ACC_W-1:0] sgn    = neg ? (flip | ~full) : flip;
  wire [ACC_W-1:0] fmt    = ch.fmt_signed ? sgn : sat;

  always_ff @(posedge ch.clk or negedge ch.rst_n) begin
    if (!ch.rst_n) begin
      int1_r   <= '0;
      int2_r   <= '0;
      last_r   <= '0;
      diff_r   <= '0;
      result_r <= 16'h0000;
      ready_r  <= 1'b0;
    end else if (ch.clr) begin
      int1_r   <= '0;
      int2_r   <= '0;
      last_r   <= '0;
      diff_r   <= '0;
      ready_r  <= 1'b0;
    end else begin
      if (ch.bit_en) begin
        int1_r <= int1_r + {{(ACC_W-1){1'b0}}, ch.bit_in}; // [R1] [R16]
        int2_r <= int2_r + int1_r; // [R1]
      end
      if (ch.word_en) begin
        last_r   <= int2_r; // [R2] [R19]
        diff_r   <= diff1; // [R2]
        result_r <= fmt[15:0]; // [R3] [R4] [R8] [R19]
      end
      ready_r <= ch.word_en; // [R19]
    end
  end

  assign ch.result = result_r;
  assign ch.ready  = ready_r;

endmodule : snc_chan

// ---- snc_top_assertions.sv ----
`timescale 1ns/1ps

// ====================
// Bus, phase and interrupt checks.
module snc_top_assertions (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        phi1_o,
  input wire logic        phi2_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // A control write that clears the enable bit stops the phase counter, so the gap and follow phase checks stand aside on any control write.
  wire        cw   = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00;
  wire        rd   = wb_ack_o && !wb_we_i;
  logic       irq_q_r;
  logic       seen_r;
  logic [8:0] nph_r;
  wire        rise = irq_o && !irq_q_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_q_r <= 1'b0;
      seen_r  <= 1'b0;
      nph_r   <= 9'h0;
    end else begin
      irq_q_r <= irq_o;
      if (cw) begin
        seen_r <= 1'b0;
        nph_r  <= 9'h0;
      end else if (rise) begin
        seen_r <= 1'b1;
        nph_r  <= 9'h0;
      end else if (phi1_o && nph_r != 9'h1ff) begin
        nph_r <= nph_r + 9'h1;
      end
    end
  end

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("request not answered");
  property p_ack_cause;
    wb_ack_o |-> wb_cyc_i && $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_phi1_gap;
    disable iff (!rstn || cw) phi1_o |=> !phi1_o [*3];
  endproperty
  a_phi1_gap: assert property (p_phi1_gap) else $error("bit clock not one in four");
  property p_phi2_follow;
    disable iff (!rstn || cw) phi1_o |-> ##2 phi2_o;
  endproperty
  a_phi2_follow: assert property (p_phi2_follow) else $error("second phase missing");
  property p_phi_excl;
    !(phi1_o && phi2_o);
  endproperty
  a_phi_excl: assert property (p_phi_excl) else $error("phases overlap");
  property p_irq_hold;
    irq_o && !wb_cyc_i |=> irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped unread");
  property p_irq_period;
    rise && seen_r |-> nph_r >= 9'd31;
  endproperty
  a_irq_period: assert property (p_irq_period) else $error("samples too close");
  property p_res_upper;
    rd && wb_adr_i[7:4] == 4'h1 |-> wb_dat_o[31:16] == 16'h0;
  endproperty
  a_res_upper: assert property (p_res_upper) else $error("result upper bits set");
  property p_unmapped;
    rd && wb_adr_i >= 8'h20 |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  c_period: cover property (rise && seen_r);
  c_phase: cover property (phi1_o ##2 phi2_o);
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule : snc_top_assertions

bind snc_top snc_top_assertions u_chk (.clock, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .phi1_o, .phi2_o, .irq_o);

// ---- snc_mod_model.sv ----
`timescale 1ns/1ps

// ====================
// Comparator stream model, one held level per channel.
module snc_mod_model (
  input wire logic       clock,
  input wire logic       phi1_o,
  input wire logic [3:0] level,
  output logic     [3:0] mod_bit
);
  initial mod_bit = 4'h0;

  // The comparator moves only on a bit-clock tick, one bit per channel.
  always @(posedge clock) begin
    if (phi1_o) begin
      mod_bit <= level;
    end
  end
endmodule : snc_mod_model

// ---- sinc2_decimator_bench.sv ----
`timescale 1ns/1ps

// ====================
// Randomised filter runs over every rate and order.
module sinc2_decimator_bench import snc_pkg::*;;
  logic        clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        phi1_o, phi2_o, irq_o, dbl;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, lvl, mod_bit, fm, sw;
  logic [1:0]  rt;
  logic [11:0] cv;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int          err_count, n_checks;

  snc_top uut (.clock, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .mod_bit, .phi1_o, .phi2_o, .irq_o);
  snc_mod_model u_mod (.clock, .phi1_o, .level(lvl), .mod_bit);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // Entered just after a rising edge; returns one edge after release.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < (4 << (5 + rt)) + 8) begin
      @(posedge clock);
      n++;
    end
    check("irq", {31'h0, irq_o}, 32'h1);
  endtask : wait_irq

  function automatic logic [31:0] exp_res(logic lv, int l, logic d2, logic sg);
    int          s, n;
    logic [31:0] v;
    s = d2 ? 2 : (l < 7 ? 4 : 5);
    n = 2 * l - s;
    v = lv ? (32'h1 << n) - 1 : 32'h0;
    if (sg)
      v = lv ? (32'h1 << (n - 1)) - 1 : 32'h10000 - (32'h1 << (n - 1));
    return v;
  endfunction : exp_res

  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, lvl} = '0;
    wb_sel_i = 4'hf;
    err_count = 0;
    n_checks = 0;
    rt = 2'h0;
    void'($urandom(54));
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    wb(1'b0, 8'h00, 32'h0);
    check("ctrl reset", q, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    check("mask reset", q, 32'h0);
    wb(1'b0, 8'h24, 32'h0);
    check("unmapped", q, 32'h0);
    wb(1'b1, 8'h08, 32'h1);
    for (int k = 0; k < 8; k++) begin
      rt = k[1:0];
      dbl = k[2];
      fm = 4'($urandom);
      sw = 4'($urandom);
      lvl <= (k < 2) ? {4{k[0]}} : 4'($urandom);
      wb(1'b1, 8'h00, ($urandom & 32'hfff) | 32'h1);
      cv = {sw, fm, dbl, rt, 1'b1};
      wb(1'b1, 8'h00, {20'h0, cv});
      // The timer restarts on the write and sees at most one tick before the read.
      wb(1'b0, 8'h0c, 32'h0);
      check("timer restart", {25'h0, q[7:1]}, 32'h0);
      wb(1'b0, 8'h00, 32'h0);
      check("ctrl", q, {20'h0, cv});
      // Two startup samples are dropped; the second one raises overrun.
      wait_irq;
      repeat ((4 << (5 + rt)) + 4) @(posedge clock);
      wb(1'b0, 8'h04, 32'h0);
      check("status", q, 32'h3);
      wb(1'b0, 8'h04, 32'h0);
      check("status clear", q, 32'h0);
      check("irq low", {31'h0, irq_o}, 32'h0);
      wait_irq;
      wb(1'b0, 8'h04, 32'h0);
      check("status", q, 32'h1);
      for (int c = 0; c < 4; c++) begin
        wb(1'b0, 8'h10 + 8'(c * 4), 32'h0);
        check("result", q, exp_res(lvl[c], 5 + rt, dbl, fm[c]));
      end
    end
    wb(1'b1, 8'h08, 32'h0);
    repeat (1032) @(posedge clock);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    check("status masked", q, 32'h1);
    // Disabling the filter must stop the timer and the first phase.
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b0, 8'h0c, 32'h0);
    check("timer idle", q, 32'h0);
    check("phase idle", {31'h0, phi1_o}, 32'h0);
    end_of_test;
  end

  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    end_of_test;
  end
endmodule : sinc2_decimator_bench
